//--- rtl/eeprom_front_pkg.sv
// Purpose: shared constants and types of the serial EEPROM command front end
// Assumes: mode 0 link, op-codes and data most significant bit first
// Notes:   Operation summary follows
//
// Operation
// - device is slave; serial clock only input
// - all bytes shifted most significant bit first
// - first byte after select is op-code
// - bad op-code: no shifting, output off
// - deselected: ignore input, output off
// - hold pauses transfer without resetting it
// - while held: output off, input ignored
// - guard pin low plus enable refuses status writes
// - guard fall during frame aborts status write
// - enable bit zero makes guard pin ignored
// - 8-bit instruction; select fall starts all
// - decode set, clear latch and status read
// - decode status write, array read, array write
// - write latch cleared at power up
// - clear latch disables programming regardless of pin
// - status bit 0 is busy flag
// - status bit 1 is write latch flag
// - bits 4-6 zero; all ones while busy
// - bits 2,3 protect level; bit 7 enable
// - protect bits need latch, timed write, polling
// - protect code selects none, quarter, half, all
// - while busy only status read accepted
// - write cycle end clears write latch
// - array read: 16-bit address, incrementing, wrapping

package eeprom_front_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS  = 40;        // reference clock period
	localparam int WRITE_TIME_NS  = 5_000_000; // internal_write_time, longest
	localparam int WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS; // rounds down

	// ************************************************************
	// serial framing
	// ************************************************************
	localparam int         BYTE_W      = 8;      // instruction register width
	localparam int         ADDR_BITS   = 16;     // address bits on the wire
	localparam logic [3:0] CNT_BYTE_END = 4'h7;  // last bit of a byte
	localparam logic [3:0] CNT_ADDR_END = 4'hF;  // last bit of the address
	localparam int         PAGE_BITS   = 5;      // page offset bits that wrap

	// ************************************************************
	// op-code fields (bit 3 is don't care)
	// ************************************************************
	localparam logic [3:0] OPC_UPPER     = 4'h0;  // required upper nibble
	localparam logic [2:0] OPC_SET_LATCH = 3'h6;
	localparam logic [2:0] OPC_CLR_LATCH = 3'h4;
	localparam logic [2:0] OPC_STAT_RD   = 3'h5;
	localparam logic [2:0] OPC_STAT_WR   = 3'h1;
	localparam logic [2:0] OPC_ARR_RD    = 3'h3;
	localparam logic [2:0] OPC_ARR_WR    = 3'h2;

	// ************************************************************
	// protection_and_state layout
	// ************************************************************
	localparam int         ST_BUSY_BIT  = 0;
	localparam int         ST_LATCH_BIT = 1;
	localparam int         ST_BP_LO_BIT = 2;  // block_protect_low
	localparam int         ST_BP_HI_BIT = 3;  // block_protect_high
	localparam int         ST_GUARD_BIT = 7;  // guard_pin_enable
	localparam logic [7:0] ST_ALL_ONES  = 8'hFF;
	localparam logic [1:0] BP_NONE      = 2'h0;
	localparam logic [1:0] BP_QUARTER   = 2'h1;
	localparam logic [1:0] BP_HALF      = 2'h2;
	localparam logic [1:0] BP_RESET     = 2'h0; // protect code after reset
	localparam logic       GUARD_RESET  = 1'b0; // pin enable after reset

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		CMD_NONE, CMD_SET_LATCH, CMD_CLR_LATCH, CMD_STAT_RD,
		CMD_STAT_WR, CMD_ARR_RD, CMD_ARR_WR
	} cmd_t;

	typedef enum logic [2:0] {
		PH_OPCODE, PH_ADDR, PH_DATA_IN, PH_READ_OUT,
		PH_STAT_OUT, PH_STAT_IN, PH_IGNORE
	} phase_t;

	typedef enum logic {
		WC_IDLE, WC_BUSY
	} wc_state_t;

endpackage

//--- rtl/eeprom_cell_array.sv
// Purpose: byte array with a write port and a registered read port
// Assumes: ports on unrelated clocks never touch one word at once
// Notes:   no reset on the storage, contents start undefined
`timescale 1ns/10ps

module eeprom_cell_array #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 10
) (
	input  wire logic              wr_clk_i,  // write side clock
	input  wire logic              we_i,      // write strobe
	input  wire logic [ADDR_W-1:0] waddr_i,   // write address
	input  wire logic [DATA_W-1:0] wdata_i,   // write data
	input  wire logic              rd_clk_i,  // read side clock
	input  wire logic              re_i,      // read strobe
	input  wire logic [ADDR_W-1:0] raddr_i,   // read address
	output logic      [DATA_W-1:0] rdata_o    // registered read data
);

	// ************************************************************
	// storage
	// ************************************************************
	logic [DATA_W-1:0] mem_ff [2**ADDR_W];  // the cells

	// write port
	always_ff @(posedge wr_clk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
	end

	// read port, data held between strobes
	always_ff @(posedge rd_clk_i) begin
		if (re_i) begin
			rdata_o <= mem_ff[raddr_i];
		end
	end

endmodule

//--- rtl/spi_eeprom_command_front_end.sv
// Purpose: serial slave front end: op-codes, hold, guard pin, status, array
// Assumes: si_i and hold_n_i are launched by the master on sck_i, so they
//          are treated as link-domain inputs; cs_n_i clears the frame sequencer and output shifter, not the payload
// Notes:   commits of a frame are made on the reference clock after select
//          rises; the link clock may stop between frames
`timescale 1ns/10ps

module spi_eeprom_command_front_end
	import eeprom_front_pkg::*;
#(
	parameter int ADDR_W     = 10,            // implemented array address bits
	parameter int WC_CYCLES  = WRITE_CYCLES   // internal write time in clocks
) (
	input  wire logic ref_clk_i,      // reference clock, 25 MHz
	input  wire logic sys_rst_i,      // synchronous reset, active high
	input  wire logic sck_i,          // serial clock from the master
	input  wire logic cs_n_i,         // chip select, active low
	input  wire logic si_i,           // serial data in
	input  wire logic hold_n_i,       // pause, active low
	input  wire logic wp_n_i,         // write guard pin, active low
	output logic      so_o,           // serial data out
	output logic      so_oe_o,        // serial out enable, high while driving
	output logic      busy_o,         // internal write cycle running
	output logic      write_latch_o   // write latch state
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam int WC_W = $clog2(WC_CYCLES + 1);
	localparam logic [WC_W-1:0] WC_LAST = WC_W'(WC_CYCLES - 1);

	// link domain frame state
	phase_t              phase_ff;        // where in the frame we are
	logic [3:0]          bit_cnt_ff;      // bit within byte or address
	logic [14:0]         in_sr_ff;        // received bits so far
	logic [7:0]          tx_sr_ff;        // bits still to send
	// link domain payload, held after the frame ends
	cmd_t                op_kind_ff;      // command of the last frame
	logic                op_seq_ff;       // toggles per decoded op-code
	logic                pay_ok_ff;       // a whole data byte arrived
	logic [ADDR_W-1:0]   pay_addr_ff;     // array write address
	logic [7:0]          pay_data_ff;     // last whole data byte
	logic [ADDR_W-1:0]   rd_addr_ff;      // array read pointer
	// link domain copies of reference state
	logic [4:0]          st_meta_ff;      // first synchroniser stage
	logic [4:0]          st_sync_ff;      // busy, latch, protect, enable
	// reference domain
	logic                link_rst_ff;     // holds link payload in reset
	logic [1:0]          cs_sync_ff;      // select synchroniser
	logic                cs_prev_ff;      // select, one clock older
	logic [1:0]          wp_sync_ff;      // guard pin synchroniser
	logic                wp_prev_ff;      // guard pin, one clock older
	logic [1:0]          seq_sync_ff;     // op-code toggle synchroniser
	logic                seq_seen_ff;     // toggle already committed
	logic                abort_ff;        // status write aborted this frame
	logic                latch_ff;        // write latch
	logic [1:0]          bp_ff;           // block protect code
	logic                guard_en_ff;     // guard pin enable
	logic [1:0]          bp_pend_ff;      // protect code being written
	logic                guard_pend_ff;   // enable bit being written
	logic                stat_wr_ff;      // cycle belongs to a status write
	wc_state_t           wc_state_ff;     // internal write cycle state
	logic [WC_W-1:0]     wc_cnt_ff;       // write cycle clocks elapsed
	logic                mem_we_ff;       // array write strobe

	logic [7:0]          byte_now;        // byte completing on this edge
	logic [15:0]         addr_now;        // address completing on this edge
	cmd_t                cmd_now;         // decoded and busy-gated command
	logic [7:0]          stat_byte;       // status as sent on the wire
	logic                rd_en;           // array read strobe
	logic [ADDR_W-1:0]   rd_addr_nxt;     // array read address
	logic [7:0]          mem_rdata;       // array read data
	logic                cs_rise;         // frame just ended
	logic                commit;          // frame carries a new command
	logic                guard_block;     // pin refuses status writes
	logic                wc_start_st;     // start a status write cycle
	logic                wc_start_arr;    // start an array write cycle

	// ************************************************************
	// op-code decode
	// ************************************************************
	function automatic cmd_t decode_op(input logic [7:0] op);
		cmd_t c;
		c = CMD_NONE;
		if (op[7:4] == OPC_UPPER) begin
			case (op[2:0])
				OPC_SET_LATCH: c = CMD_SET_LATCH;
				OPC_CLR_LATCH: c = CMD_CLR_LATCH;
				OPC_STAT_RD:   c = CMD_STAT_RD;
				OPC_STAT_WR:   c = CMD_STAT_WR;
				OPC_ARR_RD:    c = CMD_ARR_RD;
				OPC_ARR_WR:    c = CMD_ARR_WR;
				default:       c = CMD_NONE;
			endcase
		end
		return c;
	endfunction

	// protected range for an address under a protect code
	function automatic logic in_protect(input logic [1:0] bp,
			input logic [ADDR_W-1:0] a);
		logic p;
		p = 1'b0;
		case (bp)
			BP_NONE:    p = 1'b0;
			BP_QUARTER: p = &a[ADDR_W-1 -: 2];
			BP_HALF:    p = a[ADDR_W-1];
			default:    p = 1'b1;
		endcase
		return p;
	endfunction

	// ************************************************************
	// link domain: receive path
	// ************************************************************
	// bytes arrive msb first, completed by the bit on si_i
	assign byte_now = {in_sr_ff[6:0], si_i};
	assign addr_now = {in_sr_ff, si_i};

	// while busy every op-code but status read is dropped
	always_comb begin
		cmd_now = decode_op(byte_now);
		if (st_sync_ff[ST_BUSY_BIT] && cmd_now != CMD_STAT_RD) begin
			cmd_now = CMD_NONE;
		end
	end

	// frame sequencer, cleared whenever select is high
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			phase_ff   <= PH_OPCODE;
			bit_cnt_ff <= '0;
			in_sr_ff   <= '0;
		end else if (hold_n_i) begin
			in_sr_ff <= addr_now[14:0];
			case (phase_ff)
				PH_OPCODE: begin
					bit_cnt_ff <= (bit_cnt_ff == CNT_BYTE_END) ? '0 : bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == CNT_BYTE_END) begin
						case (cmd_now)
							CMD_STAT_RD: phase_ff <= PH_STAT_OUT;
							CMD_STAT_WR: phase_ff <= PH_STAT_IN;
							CMD_ARR_RD:  phase_ff <= PH_ADDR;
							CMD_ARR_WR:  phase_ff <= PH_ADDR;
							default:     phase_ff <= PH_IGNORE;
						endcase
					end
				end
				PH_ADDR: begin
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == CNT_ADDR_END) begin
						phase_ff <= (op_kind_ff == CMD_ARR_RD) ? PH_READ_OUT : PH_DATA_IN;
					end
				end
				PH_IGNORE: begin
					bit_cnt_ff <= '0;
				end
				default: begin
					bit_cnt_ff <= (bit_cnt_ff == CNT_BYTE_END) ? '0 : bit_cnt_ff + 4'h1;
				end
			endcase
		end
	end

	// payload capture, kept after the frame for the reference side
	always_ff @(posedge sck_i or posedge link_rst_ff) begin
		if (link_rst_ff) begin
			op_kind_ff  <= CMD_NONE;
			op_seq_ff   <= 1'b0;
			pay_ok_ff   <= 1'b0;
			pay_addr_ff <= '0;
			pay_data_ff <= '0;
			rd_addr_ff  <= '0;
		end else if (hold_n_i) begin
			case (phase_ff)
				PH_OPCODE: begin
					if (bit_cnt_ff == CNT_BYTE_END) begin
						op_kind_ff <= cmd_now;
						op_seq_ff  <= ~op_seq_ff;
						pay_ok_ff  <= 1'b0;
					end
				end
				PH_ADDR: begin
					if (bit_cnt_ff == CNT_ADDR_END) begin
						pay_addr_ff <= addr_now[ADDR_W-1:0];
						rd_addr_ff  <= addr_now[ADDR_W-1:0];
					end
				end
				PH_DATA_IN, PH_STAT_IN: begin
					if (bit_cnt_ff == CNT_BYTE_END) begin
						pay_data_ff <= byte_now;
						pay_ok_ff   <= 1'b1;
						// later bytes of a page wrap within the page
						if (pay_ok_ff && phase_ff == PH_DATA_IN) begin
							pay_addr_ff[PAGE_BITS-1:0] <= pay_addr_ff[PAGE_BITS-1:0]
								+ PAGE_BITS'(1);
						end
					end
				end
				PH_READ_OUT: begin
					if (bit_cnt_ff == CNT_BYTE_END) begin
						rd_addr_ff <= rd_addr_ff + ADDR_W'(1);
					end
				end
				default: begin
					op_kind_ff <= op_kind_ff;
				end
			endcase
		end
	end

	// reference state brought onto the link clock
	always_ff @(posedge sck_i) begin
		st_meta_ff <= {guard_en_ff, bp_ff, latch_ff, wc_state_ff == WC_BUSY};
		st_sync_ff <= st_meta_ff;
	end

	// ************************************************************
	// link domain: transmit path
	// ************************************************************
	// status byte as polled by the master
	always_comb begin
		stat_byte                = '0;
		stat_byte[ST_BUSY_BIT]   = st_sync_ff[0];
		stat_byte[ST_LATCH_BIT]  = st_sync_ff[1];
		stat_byte[ST_BP_LO_BIT]  = st_sync_ff[2];
		stat_byte[ST_BP_HI_BIT]  = st_sync_ff[3];
		stat_byte[ST_GUARD_BIT]  = st_sync_ff[4];
		if (st_sync_ff[0]) begin
			stat_byte = ST_ALL_ONES;
		end
	end

	// array read fetches on the edge that completes address or byte
	assign rd_en = (phase_ff == PH_ADDR && bit_cnt_ff == CNT_ADDR_END
			&& op_kind_ff == CMD_ARR_RD && hold_n_i)
		|| (phase_ff == PH_READ_OUT && bit_cnt_ff == CNT_BYTE_END && hold_n_i);
	assign rd_addr_nxt = (phase_ff == PH_ADDR) ? addr_now[ADDR_W-1:0]
		: rd_addr_ff + ADDR_W'(1);

	// output shifter, changes after falling edges
	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			so_o     <= 1'b0;
			so_oe_o  <= 1'b0;
			tx_sr_ff <= '0;
		end else if (!hold_n_i) begin
			so_oe_o <= 1'b0;
		end else begin
			case (phase_ff)
				PH_STAT_OUT, PH_READ_OUT: begin
					so_oe_o <= 1'b1;
					if (bit_cnt_ff == 4'h0) begin
						so_o     <= (phase_ff == PH_STAT_OUT) ? stat_byte[7] : mem_rdata[7];
						tx_sr_ff <= (phase_ff == PH_STAT_OUT) ? {stat_byte[6:0], 1'b0}
							: {mem_rdata[6:0], 1'b0};
					end else begin
						so_o     <= tx_sr_ff[7];
						tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
					end
				end
				default: begin
					so_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// cell array
	// ************************************************************
	eeprom_cell_array #(
		.DATA_W (BYTE_W),
		.ADDR_W (ADDR_W)
	) u_cells (
		.wr_clk_i (ref_clk_i),
		.we_i     (mem_we_ff),
		.waddr_i  (pay_addr_ff),
		.wdata_i  (pay_data_ff),
		.rd_clk_i (sck_i),
		.re_i     (rd_en),
		.raddr_i  (rd_addr_nxt),
		.rdata_o  (mem_rdata)
	);

	// ************************************************************
	// reference domain: crossings
	// ************************************************************
	// pins and the op-code toggle pass two flops
	always_ff @(posedge ref_clk_i) begin
		link_rst_ff <= sys_rst_i;
		cs_sync_ff  <= {cs_sync_ff[0], cs_n_i};
		wp_sync_ff  <= {wp_sync_ff[0], wp_n_i};
		seq_sync_ff <= {seq_sync_ff[0], op_seq_ff};
		cs_prev_ff  <= cs_sync_ff[1];
		wp_prev_ff  <= wp_sync_ff[1];
	end

	assign cs_rise     = cs_sync_ff[1] && !cs_prev_ff;
	assign commit      = cs_rise && (seq_sync_ff[1] != seq_seen_ff);
	assign guard_block = guard_en_ff && !wp_sync_ff[1];
	assign wc_start_st = commit && wc_state_ff == WC_IDLE && op_kind_ff == CMD_STAT_WR
		&& pay_ok_ff && latch_ff && !guard_block && !abort_ff;
	assign wc_start_arr = commit && wc_state_ff == WC_IDLE && op_kind_ff == CMD_ARR_WR
		&& pay_ok_ff && latch_ff && !in_protect(bp_ff, pay_addr_ff);

	// remembers which frame has been acted on
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			seq_seen_ff <= 1'b0;
		end else if (cs_rise) begin
			seq_seen_ff <= seq_sync_ff[1];
		end
	end

	// guard pin falling inside a frame kills its status write
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			abort_ff <= 1'b0;
		end else if (!cs_sync_ff[1] && guard_en_ff && wp_prev_ff && !wp_sync_ff[1]) begin
			abort_ff <= 1'b1;
		end else if (!cs_sync_ff[1] && cs_prev_ff) begin
			abort_ff <= 1'b0;
		end
	end

	// ************************************************************
	// reference domain: write latch and protection bits
	// ************************************************************
	// latch: set and clear commands, dropped at cycle end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			latch_ff <= 1'b0;
		end else if (wc_state_ff == WC_BUSY && wc_cnt_ff == WC_LAST) begin
			latch_ff <= 1'b0;
		end else if (commit && wc_state_ff == WC_IDLE) begin
			if (op_kind_ff == CMD_SET_LATCH) begin
				latch_ff <= 1'b1;
			end else if (op_kind_ff == CMD_CLR_LATCH) begin
				latch_ff <= 1'b0;
			end
		end
	end

	// protection bits take their new value when the cycle completes
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			bp_ff         <= BP_RESET;
			guard_en_ff   <= GUARD_RESET;
			bp_pend_ff    <= BP_RESET;
			guard_pend_ff <= GUARD_RESET;
			stat_wr_ff    <= 1'b0;
		end else if (wc_start_st || wc_start_arr) begin
			bp_pend_ff    <= pay_data_ff[ST_BP_HI_BIT:ST_BP_LO_BIT];
			guard_pend_ff <= pay_data_ff[ST_GUARD_BIT];
			stat_wr_ff    <= wc_start_st;
		end else if (wc_state_ff == WC_BUSY && wc_cnt_ff == WC_LAST && stat_wr_ff) begin
			bp_ff       <= bp_pend_ff;
			guard_en_ff <= guard_pend_ff;
		end
	end

	// ************************************************************
	// reference domain: internal write cycle
	// ************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wc_state_ff <= WC_IDLE;
			wc_cnt_ff   <= '0;
			mem_we_ff   <= 1'b0;
		end else begin
			mem_we_ff <= wc_start_arr;
			case (wc_state_ff)
				WC_IDLE: begin
					wc_cnt_ff <= '0;
					if (wc_start_st || wc_start_arr) begin
						wc_state_ff <= WC_BUSY;
					end
				end
				WC_BUSY: begin
					wc_cnt_ff <= wc_cnt_ff + WC_W'(1);
					if (wc_cnt_ff == WC_LAST) begin
						wc_state_ff <= WC_IDLE;
					end
				end
				default: begin
					wc_state_ff <= WC_IDLE;
				end
			endcase
		end
	end

	// flags shown beside the serial link
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			busy_o        <= 1'b0;
			write_latch_o <= 1'b0;
		end else begin
			busy_o        <= (wc_state_ff == WC_BUSY);
			write_latch_o <= latch_ff;
		end
	end

endmodule

//--- tb/spi_master_model.sv
// Purpose: mode 0 serial master that drives the front end
// Assumes: link clock of 32 ns, made only inside frames
// Notes:   after each byte the data line shows the inverse of its last bit
`timescale 1ns/10ps
module spi_master_model (
	output logic      sck_o,     // link clock, idle low
	output logic      cs_n_o,    // select, active low
	output logic      si_o,      // data to the device
	output logic      hold_n_o,  // pause, active low
	input  wire logic so_i,      // data from the device
	input  wire logic so_oe_i    // device drives so_i
);
	// idle bus: deselected, clock low
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b1;
		hold_n_o = 1'b1;
	end
	// one pulse: sample on the rise, device launches after the fall
	task automatic pulse(output logic smp);
		#16 sck_o = 1'b1;
		smp = so_i;
		#16 sck_o = 1'b0;
	endtask
	// one byte, both ways, most significant bit first
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_o = tx[i];
			pulse(rx[i]);
		end
		si_o = ~tx[0];
	endtask
	// frame opens with the select fall
	task automatic sel();
		cs_n_o = 1'b0;
		#30;
	endtask
	// long gap so the frame is committed before the next one
	task automatic desel();
		#200 cs_n_o = 1'b1;
		#400;
	endtask
	// pause over two pulses; hold moves mid low phase, never on a clock edge
	task automatic pause(output logic off);
		logic d;
		#8 hold_n_o = 1'b0;
		si_o = ~si_o;
		pulse(d);
		pulse(d);
		#8 off = !so_oe_i;
		hold_n_o = 1'b1;
	endtask
endmodule

//--- tb/front_end_chk.sv
// Purpose: concurrent checks on the front end ports
// Assumes: bound to every front end instance
// Notes:   bits_ff counts link clock rises within one frame
`timescale 1ns/10ps
module front_end_chk #(
	parameter int WC_CYCLES = 50
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic hold_n_i,
	input wire logic so_oe_o,
	input wire logic busy_o,
	input wire logic write_latch_o
);
	logic [4:0] bits_ff;  // clock rises in this frame, frozen in pause
	int         run_ff;   // cycles of the current write
	// frame bit counter, cleared by deselect
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i)
			bits_ff <= 5'h00;
		else if (hold_n_i && bits_ff != 5'h1F)
			bits_ff <= bits_ff + 5'h01;
	end
	// write cycle length
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !busy_o)
			run_ff <= 0;
		else
			run_ff <= run_ff + 1;
	end
	sequence s_run;
		busy_o [*8];
	endsequence
	property p_desel_off;
		@(posedge ref_clk_i) disable iff (sys_rst_i) cs_n_i |-> !so_oe_o;
	endproperty
	property p_reset_clear;
		@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(sys_rst_i) |-> !busy_o && !write_latch_o;
	endproperty
	property p_busy_holds;
		@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(busy_o) |-> s_run;
	endproperty
	property p_run_len;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			$fell(busy_o) |-> run_ff inside {[WC_CYCLES-1:WC_CYCLES+1]};
	endproperty
	property p_end_clears;
		@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(busy_o) |-> !write_latch_o;
	endproperty
	property p_start_cond;
		@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(busy_o) |-> write_latch_o && cs_n_i;
	endproperty
	property p_latch_idle;
		@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(write_latch_o) |-> !$past(busy_o);
	endproperty
	property p_hold_off;
		@(posedge sck_i) disable iff (cs_n_i) !hold_n_i && !$past(hold_n_i) |-> !so_oe_o;
	endproperty
	property p_oe_start;
		@(posedge sck_i) disable iff (cs_n_i) $rose(so_oe_o)
			|-> bits_ff == 5'h08 || bits_ff == 5'h18 || !$past(hold_n_i, 2);
	endproperty
	a_desel_off:   assert property (p_desel_off) else $error("output on while deselected");
	a_reset_clear: assert property (p_reset_clear) else $error("flags set after reset");
	a_busy_holds:  assert property (p_busy_holds) else $error("write cycle too short");
	a_run_len:     assert property (p_run_len) else $error("write cycle length wrong");
	a_end_clears:  assert property (p_end_clears) else $error("latch kept after write");
	a_start_cond:  assert property (p_start_cond) else $error("write without latch");
	a_latch_idle:  assert property (p_latch_idle) else $error("latch set while busy");
	a_hold_off:    assert property (p_hold_off) else $error("output on during pause");
	a_oe_start:    assert property (p_oe_start) else $error("output on at wrong bit");
endmodule
bind spi_eeprom_command_front_end front_end_chk #(.WC_CYCLES(WC_CYCLES)) front_end_chk_inst (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
	.hold_n_i(hold_n_i), .so_oe_o(so_oe_o), .busy_o(busy_o), .write_latch_o(write_latch_o)
);

//--- tb/testbench.sv
// Purpose: self-checking bench for the serial EEPROM front end
// Assumes: internal write shortened to 50 reference clocks
// Notes:   master model makes the link clock inside frames only
`timescale 1ns/10ps
module testbench;
	import eeprom_front_pkg::*;
	logic ref_clk_i = 1'b0;  // reference clock
	logic sys_rst_i = 1'b1;  // reset, held at start
	logic wp_n_i    = 1'b1;  // write guard pin
	logic sck_i, cs_n_i, si_i, hold_n_i, so_o, so_oe_o, busy_o, write_latch_o;
	int   n_errors  = 0;
	int   compares  = 0;
	logic [7:0] r;           // byte read back
	logic       off;         // output stayed off
	always #20 ref_clk_i = ~ref_clk_i;
	spi_eeprom_command_front_end #(.WC_CYCLES(50)) spi_eeprom_command_front_end_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
		.si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
		.busy_o(busy_o), .write_latch_o(write_latch_o));
	spi_master_model spi_master_model_inst (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i),
		.hold_n_o(hold_n_i), .so_i(so_o), .so_oe_i(so_oe_o));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic xb(input logic [7:0] t);
		spi_master_model_inst.xb(t, r);
	endtask
	// frame of one or two bytes
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input bit two);
		spi_master_model_inst.sel();
		xb(op);
		if (two)
			xb(d);
		spi_master_model_inst.desel();
	endtask
	// status read, second copy of the byte is kept
	task automatic status_read_cmd();
		spi_master_model_inst.sel();
		xb(8'h05);
		xb(8'h00);
		xb(8'h00);
		spi_master_model_inst.desel();
	endtask
	task automatic aw(input logic [15:0] a, input logic [7:0] d);
		cmd(8'h06, 8'h00, 0);
		spi_master_model_inst.sel();
		xb(8'h02);
		xb(a[15:8]);
		xb(a[7:0]);
		xb(d);
		spi_master_model_inst.desel();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 200 && busy_o !== 1'b0; i++)
			@(posedge ref_clk_i);
		if (busy_o !== 1'b0) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic gp(input logic v);
		@(posedge ref_clk_i);
		#1 wp_n_i = v;
	endtask
	task automatic t_reset();
		chk({busy_o, write_latch_o}, 8'h00);
		status_read_cmd();
		chk(r, 8'h00);
		chk(so_oe_o, 8'h00);
	endtask
	task automatic t_latch();
		cmd(8'h0E, 8'h00, 0);
		chk(write_latch_o, 8'h01);
		status_read_cmd();
		chk(r, 8'h02);
		cmd(8'h0C, 8'h00, 0);
		chk(write_latch_o, 8'h00);
		spi_master_model_inst.sel();
		xb(8'h86);
		xb(8'h05);
		chk(so_oe_o, 8'h00);
		spi_master_model_inst.desel();
		chk(write_latch_o, 8'h00);
	endtask
	task automatic t_hold();
		cmd(8'h06, 8'h00, 0);
		spi_master_model_inst.sel();
		xb(8'h05);
		xb(8'h00);
		spi_master_model_inst.pause(off);
		chk(off, 8'h01);
		xb(8'h00);
		chk(r, 8'h02);
		spi_master_model_inst.desel();
	endtask
	task automatic t_array();
		aw(16'h03FF, 8'hA5);
		wait_idle();
		aw(16'h0000, 8'h5A);
		wait_idle();
		cmd(8'h03, 8'h03, 1);
		spi_master_model_inst.sel();
		xb(8'h0B);
		xb(8'h03);
		xb(8'hFF);
		xb(8'h00);
		chk(r, 8'hA5);
		xb(8'h00);
		chk(r, 8'h5A);
		spi_master_model_inst.desel();
	endtask
	task automatic t_status();
		cmd(8'h06, 8'h00, 0);
		cmd(8'h01, 8'h84, 1);
		chk(busy_o, 8'h01);
		status_read_cmd();
		chk(r, ST_ALL_ONES);
		wait_idle();
		chk(write_latch_o, 8'h00);
		status_read_cmd();
		chk(r, 8'h84);
		aw(16'h0300, 8'h3C);
		chk(busy_o, 8'h00);
	endtask
	task automatic t_guard();
		gp(1'b0);
		cmd(8'h01, 8'h00, 1);
		chk(busy_o, 8'h00);
		gp(1'b1);
		spi_master_model_inst.sel();
		xb(8'h01);
		xb(8'h00);
		gp(1'b0);
		gp(1'b1);
		spi_master_model_inst.desel();
		chk(busy_o, 8'h00);
		gp(1'b1);
		cmd(8'h01, 8'h00, 1);
		wait_idle();
		gp(1'b0);
		cmd(8'h06, 8'h00, 0);
		cmd(8'h01, 8'h04, 1);
		wait_idle();
		status_read_cmd();
		chk(r, 8'h04);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		t_reset();
		t_latch();
		t_hold();
		t_array();
		t_status();
		t_guard();
		wrap_up();
	end
endmodule
